// ---- rtl/cfr_regs.sv ----
/*
 * Cache identification and feature trap register bank.
 * Assumes the pipeline presents one access per cycle on req and that
 * configuration straps are stable while the core runs.
 */
`timescale 1ns/100ps
module cfr_regs
    import cfr_pkg::*;
#(
    parameter int SEL_WIDTH = CFR_SELECTION_WIDTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Configuration straps
    input wire cfr_l2_size_t l2_size,
    input wire logic l3_present,
    // Access port
    input wire cfr_req_t req,
    output logic [63:0] rdata,
    output logic rvalid,
    // Instruction classification and trap
    input wire logic insn_uses_fp,
    output logic fp_trap_to_top
);

    // ----------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------
    if (SEL_WIDTH != CFR_SELECTION_WIDTH) begin : g_bad_sel
        $error("cache selection width must be 4");
    end

    logic [SEL_WIDTH-1:0] cache_selection;
    logic [SEL_WIDTH-1:0] next_cache_selection;
    logic [31:0] cache_size_id;
    cfr_level_id_t level_id;
    logic [31:0] ctrl_l1;
    logic [31:0] trap_l2;
    logic [31:0] trap_l3;
    logic [63:0] next_rdata;
    logic next_rvalid;
    logic wr_l1;
    logic wr_l2;
    logic wr_l3;

    // ----------------------------------------------------------------
    // Write decode
    // ----------------------------------------------------------------
    // Identification registers have no write strobe at all
    assign wr_l1 = req.valid && req.write && (req.sel == CFR_SEL_ACCESS_CTRL_L1);
    assign wr_l2 = req.valid && req.write && (req.sel == CFR_SEL_TRAP_L2);
    assign wr_l3 = req.valid && req.write && (req.sel == CFR_SEL_TRAP_L3);

    // Cache selection register
    always_comb begin
        next_cache_selection = cache_selection;
        if (req.valid && req.write && (req.sel == CFR_SEL_CACHE_SELECTION)) begin
            next_cache_selection = req.wdata[SEL_WIDTH-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cache_selection <= '0;
        end else begin
            cache_selection <= next_cache_selection;
        end
    end

    // ----------------------------------------------------------------
    // Feature trap registers
    // ----------------------------------------------------------------
    // Level one control, trace trap bit reads zero
    cfr_word_reg #(
        .RW_MASK(CFR_L1_RW_MASK),
        .RESET_MASK(CFR_L1_RW_MASK),
        .RESET_VALUE(CFR_ZERO32)
    ) u_ctrl_l1 (
        .clk(clk),
        .rst_b(rst_b),
        .wr_en(wr_l1),
        .wr_data(req.wdata[31:0]),
        .value(ctrl_l1)
    );

    // Level two trap, writable fields not reset
    cfr_word_reg #(
        .RW_MASK(CFR_TRAP_RW_MASK),
        .RESET_MASK(CFR_ZERO32),
        .RESET_VALUE(CFR_ZERO32)
    ) u_trap_l2 (
        .clk(clk),
        .rst_b(rst_b),
        .wr_en(wr_l2),
        .wr_data(req.wdata[31:0]),
        .value(trap_l2)
    );

    // Level three trap, all writable bits reset to zero
    cfr_word_reg #(
        .RW_MASK(CFR_TRAP_RW_MASK),
        .RESET_MASK(CFR_TRAP_RW_MASK),
        .RESET_VALUE(CFR_ZERO32)
    ) u_trap_l3 (
        .clk(clk),
        .rst_b(rst_b),
        .wr_en(wr_l3),
        .wr_data(req.wdata[31:0]),
        .value(trap_l3)
    );

    // Trap decision, combinational so it meets the instruction in flight
    assign fp_trap_to_top = insn_uses_fp && trap_l3[CFR_TRAP_FP_BIT];

    // ----------------------------------------------------------------
    // Selected-cache identification
    // ----------------------------------------------------------------
    // Fixed encodings carry the field layout of write policy, sets, ways
    // and line length; unknown selections read zero
    always_comb begin
        cache_size_id = CFR_CS_RESERVED;
        if (cache_selection[SEL_WIDTH-1:1] == CFR_LEVEL_ONE) begin
            cache_size_id = cache_selection[0] ? CFR_CS_L1_INST : CFR_CS_L1_DATA;
        end else if ((cache_selection[SEL_WIDTH-1:1] == CFR_LEVEL_TWO) && !cache_selection[0]) begin
            unique case (l2_size)
                CFR_L2_256K: cache_size_id = CFR_CS_L2_256K;
                CFR_L2_512K: cache_size_id = CFR_CS_L2_512K;
                CFR_L2_1024K: cache_size_id = CFR_CS_L2_1024K;
                CFR_L2_NONE: cache_size_id = CFR_CS_RESERVED;
            endcase
        end
    end
    // Field layout

    // ----------------------------------------------------------------
    // Cache-level identification
    // ----------------------------------------------------------------
    always_comb begin
        level_id = '0;
        level_id.inner_boundary_level = l3_present ? CFR_BOUNDARY_L3 : CFR_BOUNDARY_L2;
        level_id.uniproc_unification_level = CFR_UNIFY_NONE;
        level_id.coherency_level = l3_present ? CFR_BOUNDARY_L3 : CFR_BOUNDARY_L2;
        level_id.inner_share_unification_level = CFR_UNIFY_NONE;
        level_id.level_two_cache_type = (l2_size != CFR_L2_NONE) ? CFR_TYPE_UNIFIED : CFR_TYPE_NONE;
        // Meaningless to software when level two type is zero
        level_id.level_three_cache_type = l3_present ? CFR_TYPE_UNIFIED : CFR_TYPE_NONE;
        level_id.level_one_cache_type = CFR_TYPE_SPLIT;
    end

    // ----------------------------------------------------------------
    // Read data, registered one cycle after a read request
    // ----------------------------------------------------------------
    always_comb begin
        next_rdata = rdata;
        next_rvalid = req.valid && !req.write;
        if (req.valid && !req.write) begin
            unique case (req.sel)
                CFR_SEL_CACHE_SIZE_ID: next_rdata = {32'h0, cache_size_id};
                CFR_SEL_CACHE_LEVEL_ID: next_rdata = level_id;
                CFR_SEL_ACCESS_CTRL_L1: next_rdata = {32'h0, ctrl_l1};
                CFR_SEL_TRAP_L2: next_rdata = {32'h0, trap_l2};
                CFR_SEL_TRAP_L3: next_rdata = {32'h0, trap_l3};
                CFR_SEL_CACHE_SELECTION: next_rdata = {{(64-SEL_WIDTH){1'b0}}, cache_selection};
                default: next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= '0;
            rvalid <= 1'b0;
        end else begin
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

endmodule

// ---- common/cfr_pkg.sv ----
/*
 * Constants, field layouts and types for the cache identification and
 * feature trap register bank.
 * Assumes a single processor clock and a system-register access port
 * driven by the instruction pipeline.
 */
// Function
// - Bits 31/30 flag write-through and write-back support
// - Bits 29/28 flag read and write allocation
// - Bits 27:13 hold set count minus one
// - Bits 12:3 hold way count minus one
// - Bits 2:0 hold log2 line bytes minus four
// - Level one reads 701FE01A data, 201FE01A instruction
// - Level two value follows configured size
// - Inner boundary field reports two or three
// - Uniprocessor unification level reads zero
// - Coherency level reports two or three
// - Inner shareable unification level reads zero
// - Bits 63:33 and 20:9 read zero
// - Level two type reads 100 when present
// - Level one type reads 011, split caches
// - Level one trace trap bit 28 reads zero
// - Trace trap bit 20 reads zero, levels two/three
// - Level two trap fields reset unknown
// - Level three fp trap resets to zero
// - Set fp trap traps vector/fp use everywhere
package cfr_pkg;

    // ----------------------------------------------------------------
    // Register selectors on the access port
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        CFR_SEL_CACHE_SIZE_ID,
        CFR_SEL_CACHE_LEVEL_ID,
        CFR_SEL_ACCESS_CTRL_L1,
        CFR_SEL_TRAP_L2,
        CFR_SEL_TRAP_L3,
        CFR_SEL_CACHE_SELECTION
    } cfr_reg_sel_t;

    // ----------------------------------------------------------------
    // Selected-cache identification field positions
    // ----------------------------------------------------------------
    localparam int CFR_CS_WT_BIT = 31;
    localparam int CFR_CS_WB_BIT = 30;
    localparam int CFR_CS_RA_BIT = 29;
    localparam int CFR_CS_WA_BIT = 28;
    localparam int CFR_CS_SETS_HI = 27;
    localparam int CFR_CS_SETS_LO = 13;
    localparam int CFR_CS_WAYS_HI = 12;
    localparam int CFR_CS_WAYS_LO = 3;
    localparam int CFR_CS_LINE_HI = 2;
    localparam int CFR_CS_LINE_LO = 0;
    localparam logic [2:0] CFR_LINE_LOG2_BIAS = 3'h4;

    // Complete encodings per cache
    localparam logic [31:0] CFR_CS_L1_DATA = 32'h701FE01A;
    localparam logic [31:0] CFR_CS_L1_INST = 32'h201FE01A;
    localparam logic [31:0] CFR_CS_L2_256K = 32'h703FE03A;
    localparam logic [31:0] CFR_CS_L2_512K = 32'h707FE03A;
    localparam logic [31:0] CFR_CS_L2_1024K = 32'h70FFE03A;
    localparam logic [31:0] CFR_CS_RESERVED = 32'h00000000;

    // Cache selection: level in bits 3:1, instruction flag in bit 0
    localparam logic [2:0] CFR_LEVEL_ONE = 3'h0;
    localparam logic [2:0] CFR_LEVEL_TWO = 3'h1;
    localparam int CFR_SELECTION_WIDTH = 4;

    // ----------------------------------------------------------------
    // Cache-level identification fields
    // ----------------------------------------------------------------
    localparam logic [2:0] CFR_BOUNDARY_L2 = 3'h2;
    localparam logic [2:0] CFR_BOUNDARY_L3 = 3'h3;
    localparam logic [2:0] CFR_UNIFY_NONE = 3'h0;
    localparam logic [2:0] CFR_TYPE_UNIFIED = 3'h4;
    localparam logic [2:0] CFR_TYPE_NONE = 3'h0;
    localparam logic [2:0] CFR_TYPE_SPLIT = 3'h3;

    typedef struct packed {
        logic [30:0] zero_hi;
        logic [2:0] inner_boundary_level;
        logic [2:0] uniproc_unification_level;
        logic [2:0] coherency_level;
        logic [2:0] inner_share_unification_level;
        logic [11:0] zero_mid;
        logic [2:0] level_three_cache_type;
        logic [2:0] level_two_cache_type;
        logic [2:0] level_one_cache_type;
    } cfr_level_id_t;

    // L2 size configuration codes
    typedef enum logic [1:0] {
        CFR_L2_256K,
        CFR_L2_512K,
        CFR_L2_1024K,
        CFR_L2_NONE
    } cfr_l2_size_t;

    // ----------------------------------------------------------------
    // Feature trap fields
    // ----------------------------------------------------------------
    localparam int CFR_L1_TRACE_BIT = 28;
    localparam int CFR_TRAP_TRACE_BIT = 20;
    localparam int CFR_TRAP_FP_BIT = 10;
    localparam logic [31:0] CFR_L1_RW_MASK = 32'h0FFFFFFF;
    localparam logic [31:0] CFR_TRAP_RW_MASK = 32'hFFEFFFFF;
    localparam logic [31:0] CFR_ZERO32 = 32'h00000000;

    // Access request from the pipeline
    typedef struct packed {
        logic valid;
        logic write;
        cfr_reg_sel_t sel;
        logic [63:0] wdata;
    } cfr_req_t;

endpackage

// ---- rtl/cfr_word_reg.sv ----
/*
 * One 32-bit writable system register with a per-bit writable mask and
 * a per-bit reset mask; bits outside the writable mask read zero.
 * Assumes writes are one-cycle pulses from the access decoder.
 */
`timescale 1ns/100ps
module cfr_word_reg
    import cfr_pkg::*;
#(
    parameter logic [31:0] RW_MASK = 32'hFFFFFFFF,
    parameter logic [31:0] RESET_MASK = 32'h00000000,
    parameter logic [31:0] RESET_VALUE = 32'h00000000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Write port
    input wire logic wr_en,
    input wire logic [31:0] wr_data,
    // Stored value
    output logic [31:0] value
);

    logic [31:0] next_value;

    // Parameter check: a reset bit that cannot be written would still get a reset flop
    if ((RESET_MASK & ~RW_MASK) != 32'h00000000) begin : g_bad_mask
        $error("reset mask must lie inside the writable mask");
    end

    // Next value: only writable bits take write data
    always_comb begin
        next_value = value;
        if (wr_en) begin
            next_value = wr_data & RW_MASK;
        end
    end

    // Per-bit storage: reset bits load RESET_VALUE, other writable bits hold unknown reset
    genvar i;
    generate
        for (i = 0; i < 32; i++) begin : g_bit
            if (RESET_MASK[i]) begin : g_rst
                logic stored;
                // Own flop per bit keeps reset and plain bits in separate variables
                always_ff @(posedge clk or negedge rst_b) begin
                    if (!rst_b) begin
                        stored <= RESET_VALUE[i];
                    end else begin
                        stored <= next_value[i];
                    end
                end
                assign value[i] = stored;
            end else if (RW_MASK[i]) begin : g_norst
                logic stored;
                always_ff @(posedge clk) begin
                    stored <= next_value[i];
                end
                assign value[i] = stored;
            end else begin : g_zero
                assign value[i] = 1'b0;
            end
        end
    endgenerate

endmodule

// ---- test/cfr_regs_checker.sv ----
/*
 * Port checker for the cache identification and feature trap bank.
 * Assumes it is bound to cfr_regs and sees only its ports.
 */
`timescale 1ns/100ps
module cfr_regs_checker
    import cfr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Straps and access port
    input wire cfr_l2_size_t l2_size,
    input wire logic l3_present,
    input wire cfr_req_t req,
    input wire logic [63:0] rdata,
    input wire logic rvalid,
    // Trap
    input wire logic insn_uses_fp,
    input wire logic fp_trap_to_top
);
    logic [3:0] sel_q;
    logic [3:0] next_sel_q;
    logic rd_any;
    logic rd_size;
    logic rd_lvl;
    logic [2:0] lv;
    logic fp_en;
    logic next_fp_en;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ------------------------------------------------------------
    // Helper: shadow of the cache selection
    // ------------------------------------------------------------
    assign rd_any = req.valid && !req.write;
    assign rd_size = rd_any && req.sel == CFR_SEL_CACHE_SIZE_ID;
    assign rd_lvl = rd_any && req.sel == CFR_SEL_CACHE_LEVEL_ID;
    assign lv = l3_present ? 3'h3 : 3'h2;
    // Next selection on a write to the selection register
    always_comb begin
        next_sel_q = sel_q;
        if (req.valid && req.write && req.sel == CFR_SEL_CACHE_SELECTION) begin
            next_sel_q = req.wdata[3:0];
        end
    end
    // Register the selection
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_q <= 4'h0;
        end else begin
            sel_q <= next_sel_q;
        end
    end
    // Shadow of the level three fp trap enable, cleared by reset
    always_comb begin
        next_fp_en = fp_en;
        if (req.valid && req.write && req.sel == CFR_SEL_TRAP_L3) begin
            next_fp_en = req.wdata[CFR_TRAP_FP_BIT];
        end
    end
    // Register the enable shadow
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fp_en <= 1'b0;
        end else begin
            fp_en <= next_fp_en;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_answer; rd_any |=> rvalid; endproperty
    property p_quiet; !rd_any |=> !rvalid; endproperty
    property p_l1; rd_size && sel_q[3:1] == 3'h0 |=> rdata == {32'h0, sel_q[0] ? CFR_CS_L1_INST : CFR_CS_L1_DATA};
    endproperty
    property p_l2; rd_size && sel_q == 4'h2 && l2_size != CFR_L2_NONE |=> rdata == {32'h0,
        l2_size == CFR_L2_256K ? CFR_CS_L2_256K : l2_size == CFR_L2_512K ? CFR_CS_L2_512K : CFR_CS_L2_1024K};
    endproperty
    property p_rsv; rd_size && sel_q > 4'h2 |=> rdata == 64'h0; endproperty
    property p_lvl; rd_lvl |=> rdata[63:9] == {31'h0, lv, 3'h0, lv, 15'h0} && rdata[2:0] == 3'h3; endproperty
    property p_type2; rd_lvl |=> rdata[5:3] == (l2_size == CFR_L2_NONE ? 3'h0 : 3'h4); endproperty
    property p_trace1; rd_any && req.sel == CFR_SEL_ACCESS_CTRL_L1 |=> rdata[31:28] == 4'h0; endproperty
    property p_trace23; rd_any && (req.sel == CFR_SEL_TRAP_L2 || req.sel == CFR_SEL_TRAP_L3) |=> !rdata[20];
    endproperty
    property p_fp_rst; $rose(rst_b) |-> !fp_trap_to_top; endproperty
    property p_fp_gate; fp_trap_to_top |-> insn_uses_fp; endproperty
    property p_fp_set; fp_trap_to_top == (insn_uses_fp && fp_en); endproperty
    a_answer: assert property (p_answer) else $error("read not answered");
    a_quiet: assert property (p_quiet) else $error("answer without read");
    a_l1: assert property (p_l1) else $error("level one id wrong");
    a_l2: assert property (p_l2) else $error("level two id wrong");
    a_rsv: assert property (p_rsv) else $error("reserved selection not zero");
    a_lvl: assert property (p_lvl) else $error("level id fields wrong");
    a_type2: assert property (p_type2) else $error("level two type wrong");
    a_trace1: assert property (p_trace1) else $error("ctrl top bits set");
    a_trace23: assert property (p_trace23) else $error("trace bit set");
    a_fp_rst: assert property (p_fp_rst) else $error("trap active after reset");
    a_fp_gate: assert property (p_fp_gate) else $error("trap without fp use");
    a_fp_set: assert property (p_fp_set) else $error("trap differs from enable");
    // Main scenarios
    c_l2: cover property (rd_size && sel_q == 4'h2);
    c_l3: cover property (rd_lvl && l3_present);
    c_fp: cover property (fp_trap_to_top);
endmodule

// ---- test/cfr_regs_tb.sv ----
/*
 * Self-checking bench for cfr_regs with an integer reference model.
 * Assumes the package cfr_pkg and the checker are compiled first.
 */
`timescale 1ns/100ps
module cfr_regs_tb;
    import cfr_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    cfr_l2_size_t l2_size = CFR_L2_256K;
    logic l3_present = 1'b0;
    cfr_req_t req = '0;
    logic insn_uses_fp = 1'b0;
    logic [63:0] rdata;
    logic rvalid;
    logic fp_trap_to_top;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [63:0] seen;
    logic [63:0] mask;
    logic [31:0] rnd;
    cfr_reg_sel_t regs [3] = '{CFR_SEL_ACCESS_CTRL_L1, CFR_SEL_TRAP_L2, CFR_SEL_TRAP_L3};
    logic [31:0] masks [3] = '{CFR_L1_RW_MASK, CFR_TRAP_RW_MASK, CFR_TRAP_RW_MASK};
    cfr_regs cfr_regs_inst (.clk(clk), .rst_b(rst_b), .l2_size(l2_size), .l3_present(l3_present), .req(req),
        .rdata(rdata), .rvalid(rvalid), .insn_uses_fp(insn_uses_fp), .fp_trap_to_top(fp_trap_to_top));
    // ------------------------------------------------------------
    // Clock, timeout and helpers
    // ------------------------------------------------------------
    always #10 clk = ~clk;
    // Cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            give_verdict();
        end
    end
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input cfr_reg_sel_t s, input logic [63:0] d);
        @(posedge clk);
        req <= '{valid: 1'b1, write: 1'b1, sel: s, wdata: d};
        @(posedge clk);
        req.valid <= 1'b0;
    endtask
    task automatic rd(input cfr_reg_sel_t s, output logic [63:0] d);
        @(posedge clk);
        req <= '{valid: 1'b1, write: 1'b0, sel: s, wdata: 64'h0};
        @(posedge clk);
        req.valid <= 1'b0;
        #1;
        check({63'h0, rvalid}, 64'h1);
        d = rdata;
    endtask
    // Reference model of the identification values
    function automatic logic [31:0] size_exp(int s, int l2);
        case (s)
            0: return CFR_CS_L1_DATA;
            1: return CFR_CS_L1_INST;
            2: return l2 == 0 ? CFR_CS_L2_256K : l2 == 1 ? CFR_CS_L2_512K : l2 == 2 ? CFR_CS_L2_1024K : 32'h0;
            default: return 32'h0;
        endcase
    endfunction
    function automatic logic [63:0] lvl_exp(int l2, logic l3);
        logic [2:0] lv;
        lv = l3 ? 3'h3 : 3'h2;
        return {31'h0, lv, 3'h0, lv, 3'h0, 12'h0, l3 ? 3'h4 : 3'h0, l2 == 3 ? 3'h0 : 3'h4, 3'h3};
    endfunction
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hFA24A3D0));
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        rd(CFR_SEL_TRAP_L3, seen);
        check(seen, 64'h0);
        @(posedge clk);
        insn_uses_fp <= 1'b1;
        #1;
        check({63'h0, fp_trap_to_top}, 64'h0);
        for (int c = 0; c < 8; c++) begin
            @(posedge clk);
            l2_size <= cfr_l2_size_t'(c[1:0]);
            l3_present <= c[2];
            wr(CFR_SEL_CACHE_LEVEL_ID, {$urandom, $urandom});
            rd(CFR_SEL_CACHE_LEVEL_ID, seen);
            mask = c[1:0] == 2'h3 ? ~64'h1C0 : ~64'h0;
            check(seen & mask, lvl_exp(c[1:0], c[2]) & mask);
            for (int s = 0; s < 16; s++) begin
                wr(CFR_SEL_CACHE_SELECTION, 64'(s));
                wr(CFR_SEL_CACHE_SIZE_ID, {$urandom, $urandom});
                rd(CFR_SEL_CACHE_SIZE_ID, seen);
                check(seen, {32'h0, size_exp(s, c[1:0])});
            end
            rd(CFR_SEL_CACHE_SELECTION, seen);
            check(seen, 64'h000000000000000F);
        end
        for (int i = 0; i < 12; i++) begin
            rnd = $urandom;
            rnd[10] = i[1];
            wr(regs[i % 3], {$urandom, rnd});
            rd(regs[i % 3], seen);
            check(seen, {32'h0, rnd & masks[i % 3]});
            if (i % 3 == 2) begin
                @(posedge clk);
                insn_uses_fp <= i[0];
                #1;
                check({63'h0, fp_trap_to_top}, {63'h0, i[0] & rnd[10]});
            end
        end
        rd(cfr_reg_sel_t'(3'h6), seen);
        check(seen, 64'h0);
        rd(cfr_reg_sel_t'(3'h7), seen);
        check(seen, 64'h0);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd(CFR_SEL_TRAP_L3, seen);
        check(seen, 64'h0);
        rd(CFR_SEL_ACCESS_CTRL_L1, seen);
        check(seen, 64'h0);
        check({63'h0, fp_trap_to_top}, 64'h0);
        give_verdict();
    end
endmodule
bind cfr_regs cfr_regs_checker cfr_regs_checker_inst (.clk(clk), .rst_b(rst_b), .l2_size(l2_size),
    .l3_present(l3_present), .req(req), .rdata(rdata), .rvalid(rvalid), .insn_uses_fp(insn_uses_fp),
    .fp_trap_to_top(fp_trap_to_top));
